// File: logic/gate_driver_config.v
// Configuration bank, dead-time sequencer and OTP byte of the bridge driver
`timescale 1ns/1ps
// How it works
// - Analog dead-time code 0/16/24 means 100/200/375 ns; resets to 0.
// - Digital dead time counts 0..15 internal cycles of about 83 ns.
// - The longer of analog and digital dead time is applied.
// - OTP bit 6 clear gives 4 digital cycles after reset, set gives 2.
// - Overtemp threshold select 00/01/10/11 is 150/143/136/120 C; resets 00.
// - After overtemp shutdown the bridge returns only below prewarning.
// - Gate current: weak, weak boosted when hot, medium, strong; resets 00.
// - Sense filter select 00..11 is 100..400 ns; resets 00.
// - Current_global_scale multiplies current; 0 means full scale, else n/256.
// - Offset word: phase A signed in upper byte, phase B in lower.
// - OTP byte supplies several power-up defaults, loaded at reset.
// - OTP bits start from the factory byte at reset and programming can only set them.
// - OTP bit 7 clear gives blank code 2, set gives blank code 1.
// - OTP bit 5 clear gives both short levels 6, set gives 12.
// - OTP bits 4..0 give the oscillator trim default.
// - Reading the programming register refreshes the OTP read data.
`include "gate_driver_config_defs.vh"

module gate_driver_config #(
  parameter PROG_CYCLES = `PROGRAM_CYCLES
) (
  input wire sys_clk,
  input wire rst,
  input wire wr_en,
  input wire [6:0] wr_addr,
  input wire [31:0] wr_data,
  input wire rd_en,
  input wire [6:0] rd_addr,
  output reg [31:0] rd_data,
  output reg rd_valid,
  input wire [7:0] otp_factory_bits,
  input wire [7:0] offset_phase_a,
  input wire [7:0] offset_phase_b,
  input wire [3:0] temp_above,
  input wire bridge_cmd,
  input wire [7:0] current_demand,
  output reg high_gate_on,
  output reg low_gate_on,
  output reg bridge_disabled,
  output reg overtemp_prewarning,
  output reg [1:0] gate_current_sel,
  output reg [1:0] sense_filter_sel,
  output reg [4:0] analog_deadtime,
  output reg [3:0] digital_deadtime_cycles,
  output reg [7:0] scaled_current,
  output reg [1:0] blank_time,
  output reg [3:0] ground_short_sensitivity,
  output reg [3:0] supply_short_sensitivity,
  output reg [4:0] oscillator_trim,
  output reg otp_busy
);

  localparam [2:0] ST_DEAD = 3'b001;
  localparam [2:0] ST_HIGH = 3'b010;
  localparam [2:0] ST_LOW = 3'b100;

  // Analog dead time in ns, piecewise linear over the code
  function [11:0] analog_ns;
    input [4:0] code;
    reg [31:0] t;
    begin
      if (code <= `ANALOG_MID_CODE) begin
        t = `ANALOG_MIN_NS + {27'h0000000, code} *
          (`ANALOG_MID_NS - `ANALOG_MIN_NS) / `ANALOG_MID_CODE;
      end else begin
        t = `ANALOG_MID_NS + ({27'h0000000, code} - `ANALOG_MID_CODE) *
          (`ANALOG_MAX_NS - `ANALOG_MID_NS) /
          (`ANALOG_MAX_CODE - `ANALOG_MID_CODE);
      end
      analog_ns = t[11:0]; // Longest code stays well under 4096 ns
    end
  endfunction

  // Least number of system cycles covering a time in ns
  function [6:0] ns_to_cycles;
    input [11:0] ns;
    reg [31:0] c;
    begin
      c = (ns + `CLK_PERIOD_NS - 1) / `CLK_PERIOD_NS;
      ns_to_cycles = c[6:0];
    end
  endfunction

  reg [1:0] overtemp_threshold_sel;
  reg [1:0] gate_sel_cfg;
  reg [7:0] global_scale;
  reg [7:0] fuse;
  reg [7:0] otp_read_shadow;
  reg [2:0] prog_bit;
  reg [22:0] prog_count;
  reg [3:0] temp_s1;
  reg [3:0] temp_s2;
  reg [3:0] temp_s3;
  reg [3:0] temp_level;
  reg [2:0] state;
  reg [2:0] next_state;
  reg [6:0] dead_count;
  reg [6:0] dead_cycles;
  reg [11:0] analog_time;
  reg [11:0] digital_time;
  reg [31:0] digital_wide;
  reg over_limit;
  reg [15:0] product;

  wire [3:0] temp_agree = ~(temp_s2 ^ temp_s3);
  wire wr_drv = wr_en && wr_addr == `ADDR_BRIDGE_DRIVER_CONFIG;
  wire wr_prog = wr_en && wr_addr == `ADDR_OTP_PROGRAM &&
    wr_data[`PROG_KEY_MSB:`PROG_KEY_LSB] == `PROGRAM_KEY &&
    wr_data[`PROG_BYTE_MSB:`PROG_BYTE_LSB] == `PROG_BYTE_INDEX;

  // Bridge driver configuration and current_global_scale registers
  always @(posedge sys_clk) begin
    if (rst) begin
      analog_deadtime <= `RST_ANALOG_DT;
      digital_deadtime_cycles <= otp_factory_bits[`OTP_DEADTIME_BIT] ?
        `DIGITAL_DT_OTP_SET : `DIGITAL_DT_OTP_CLR;
      overtemp_threshold_sel <= `RST_OT_SEL;
      gate_sel_cfg <= `RST_GATE_SEL;
      sense_filter_sel <= `RST_FILT_SEL;
      global_scale <= `RST_GLOBAL_SCALE;
    end else begin
      if (wr_drv) begin
        analog_deadtime <= wr_data[`ANALOG_DT_MSB:`ANALOG_DT_LSB];
        digital_deadtime_cycles <= wr_data[`DIGITAL_DT_MSB:`DIGITAL_DT_LSB];
        overtemp_threshold_sel <= wr_data[`OT_SEL_MSB:`OT_SEL_LSB];
        gate_sel_cfg <= wr_data[`GATE_SEL_MSB:`GATE_SEL_LSB];
        sense_filter_sel <= wr_data[`FILT_SEL_MSB:`FILT_SEL_LSB];
      end
      if (wr_en && wr_addr == `ADDR_CURRENT_GLOBAL_SCALE) begin
        global_scale <= wr_data[7:0]; // Writing 256 stores 0
      end
    end
  end

  // Other defaults taken from the OTP byte at reset
  always @(posedge sys_clk) begin
    if (rst) begin
      blank_time <= otp_factory_bits[`OTP_BLANK_BIT] ?
        `BLANK_OTP_SET : `BLANK_OTP_CLR;
      ground_short_sensitivity <= otp_factory_bits[`OTP_SHORT_BIT] ?
        `SHORT_OTP_SET : `SHORT_OTP_CLR;
      supply_short_sensitivity <= otp_factory_bits[`OTP_SHORT_BIT] ?
        `SHORT_OTP_SET : `SHORT_OTP_CLR;
      oscillator_trim <= otp_factory_bits[`OTP_TRIM_MSB:0];
    end
  end

  // OTP array: loads at reset, a finished program only sets one bit
  always @(posedge sys_clk) begin
    if (rst) begin
      fuse <= otp_factory_bits;
      otp_read_shadow <= otp_factory_bits;
      otp_busy <= 1'b0;
      prog_bit <= 3'h0;
      prog_count <= 23'h000000;
    end else begin
      if (otp_busy) begin
        if (prog_count == 23'h000001) begin
          otp_busy <= 1'b0;
          fuse <= fuse | (8'h01 << prog_bit);
        end
        prog_count <= prog_count - 23'h000001;
      end else if (wr_prog) begin
        otp_busy <= 1'b1;
        prog_bit <= wr_data[`PROG_BIT_MSB:`PROG_BIT_LSB];
        prog_count <= PROG_CYCLES[22:0];
      end
      if (rd_en && rd_addr == `ADDR_OTP_PROGRAM) begin
        otp_read_shadow <= fuse;
      end
    end
  end

  // Register read port, answer one cycle after the request
  always @(posedge sys_clk) begin
    if (rst) begin
      rd_data <= 32'h00000000;
      rd_valid <= 1'b0;
    end else begin
      rd_valid <= rd_en;
      rd_data <= 32'h00000000;
      if (rd_en && rd_addr == `ADDR_OTP_CONTENTS) begin
        rd_data <= {24'h000000, otp_read_shadow};
      end else if (rd_en && rd_addr == `ADDR_PHASE_OFFSET_RESULT) begin
        rd_data <= {16'h0000, offset_phase_a, offset_phase_b};
      end
    end
  end

  // Temperature comparator inputs: three stages, change on agreement
  always @(posedge sys_clk) begin
    if (rst) begin
      temp_s1 <= 4'h0;
      temp_s2 <= 4'h0;
      temp_s3 <= 4'h0;
      temp_level <= 4'h0;
    end else begin
      temp_s1 <= temp_above;
      temp_s2 <= temp_s1;
      temp_s3 <= temp_s2;
      temp_level <= (temp_level & ~temp_agree) | (temp_s3 & temp_agree);
    end
  end

  // Selected shutdown comparator; bit 0 is the prewarning level
  always @* begin
    case (overtemp_threshold_sel)
      2'h0: over_limit = temp_level[3];
      2'h1: over_limit = temp_level[2];
      2'h2: over_limit = temp_level[1];
      default: over_limit = temp_level[0];
    endcase
  end

  // Shutdown latch with release at the prewarning level
  always @(posedge sys_clk) begin
    if (rst) begin
      bridge_disabled <= 1'b0;
      overtemp_prewarning <= 1'b0;
      gate_current_sel <= `GATE_WEAK;
    end else begin
      overtemp_prewarning <= temp_level[0];
      if (over_limit) begin
        bridge_disabled <= 1'b1;
      end else if (!temp_level[0]) begin
        bridge_disabled <= 1'b0;
      end
      if (gate_sel_cfg == `GATE_WEAK_BOOST) begin
        gate_current_sel <= temp_level[0] ?
          `GATE_MEDIUM : `GATE_WEAK;
      end else begin
        gate_current_sel <= gate_sel_cfg;
      end
    end
  end

  // Dead time is the longer of the two settings
  always @* begin
    analog_time = analog_ns(analog_deadtime);
    digital_wide = {28'h0000000, digital_deadtime_cycles} *
      `DIGITAL_CYCLE_NS;
    digital_time = digital_wide[11:0]; // 15 cycles fit in 12 bits
    if (analog_time > digital_time) begin
      dead_cycles = ns_to_cycles(analog_time);
    end else begin
      dead_cycles = ns_to_cycles(digital_time);
    end
  end

  // Gate sequencer: both off for the dead time before every switch-on but the first after reset (counter resets to 0)
  always @* begin
    next_state = state;
    case (state)
      ST_DEAD: begin
        if (dead_count == 7'h00 && !bridge_disabled) begin
          next_state = bridge_cmd ? ST_HIGH : ST_LOW;
        end
      end
      ST_HIGH: begin
        if (!bridge_cmd || bridge_disabled) begin
          next_state = ST_DEAD;
        end
      end
      ST_LOW: begin
        if (bridge_cmd || bridge_disabled) begin
          next_state = ST_DEAD;
        end
      end
      default: next_state = ST_DEAD;
    endcase
  end

  // Sequencer state, dead-time counter and gate outputs
  always @(posedge sys_clk) begin
    if (rst) begin
      state <= ST_DEAD;
      dead_count <= 7'h00;
      high_gate_on <= 1'b0;
      low_gate_on <= 1'b0;
    end else begin
      state <= next_state;
      if (state != ST_DEAD && next_state == ST_DEAD) begin
        dead_count <= dead_cycles;
      end else if (state == ST_DEAD && dead_count != 7'h00) begin
        dead_count <= dead_count - 7'h01;
      end
      high_gate_on <= next_state == ST_HIGH;
      low_gate_on <= next_state == ST_LOW;
    end
  end

  // Current scaling, code 0 counts as full scale
  always @* begin
    if (global_scale == 8'h00) begin
      product = {current_demand, 8'h00};
    end else begin
      product = current_demand * global_scale;
    end
  end

  // Registered scaled current
  always @(posedge sys_clk) begin
    if (rst) begin
      scaled_current <= 8'h00;
    end else begin
      scaled_current <= product[15:8];
    end
  end

endmodule

// File: logic/gate_driver_config_defs.vh
// Offsets, field positions, reset values and timing counts of the bank
`ifndef GATE_DRIVER_CONFIG_DEFS_VH
`define GATE_DRIVER_CONFIG_DEFS_VH

// Register offsets
`define ADDR_OTP_PROGRAM 7'h06
`define ADDR_OTP_CONTENTS 7'h07
`define ADDR_BRIDGE_DRIVER_CONFIG 7'h0A
`define ADDR_CURRENT_GLOBAL_SCALE 7'h0B
`define ADDR_PHASE_OFFSET_RESULT 7'h0C

// Bridge driver configuration fields
`define ANALOG_DT_LSB 0
`define ANALOG_DT_MSB 4
`define DIGITAL_DT_LSB 8
`define DIGITAL_DT_MSB 11
`define OT_SEL_LSB 16
`define OT_SEL_MSB 17
`define GATE_SEL_LSB 18
`define GATE_SEL_MSB 19
`define FILT_SEL_LSB 20
`define FILT_SEL_MSB 21

// Programming word fields
`define PROG_BIT_LSB 0
`define PROG_BIT_MSB 2
`define PROG_BYTE_LSB 4
`define PROG_BYTE_MSB 5
`define PROG_KEY_LSB 8
`define PROG_KEY_MSB 15
`define PROGRAM_KEY 8'hBD
`define PROG_BYTE_INDEX 2'h0

// OTP bit positions
`define OTP_BLANK_BIT 7
`define OTP_DEADTIME_BIT 6
`define OTP_SHORT_BIT 5
`define OTP_TRIM_MSB 4

// Reset values
`define RST_ANALOG_DT 5'h00
`define RST_OT_SEL 2'h0
`define RST_GATE_SEL 2'h0
`define RST_FILT_SEL 2'h0
`define RST_GLOBAL_SCALE 8'h00
`define DIGITAL_DT_OTP_CLR 4'h4
`define DIGITAL_DT_OTP_SET 4'h2
`define BLANK_OTP_CLR 2'h2
`define BLANK_OTP_SET 2'h1
`define SHORT_OTP_CLR 4'h6
`define SHORT_OTP_SET 4'hC

// Gate drive codes
`define GATE_WEAK 2'h0
`define GATE_WEAK_BOOST 2'h1
`define GATE_MEDIUM 2'h2

// Timing, in ns unless stated
`define CLK_PERIOD_NS 25
`define DIGITAL_CYCLE_NS 83
`define ANALOG_MIN_NS 100
`define ANALOG_MID_NS 200
`define ANALOG_MAX_NS 375
`define ANALOG_MID_CODE 16
`define ANALOG_MAX_CODE 24
`define PROGRAM_TIME_MS 10
`define PROGRAM_CYCLES (`PROGRAM_TIME_MS * 1000000 / `CLK_PERIOD_NS)

`endif

// File: verification/config_host.sv
// Host model issuing register writes, reads and programming words
`timescale 1ns/1ps
module config_host (
  input wire sys_clk,
  output reg wr_en,
  output reg [6:0] wr_addr,
  output reg [31:0] wr_data,
  output reg rd_en,
  output reg [6:0] rd_addr,
  input wire [31:0] rd_data,
  input wire rd_valid
);
  // Strobes idle from time zero
  initial begin
    wr_en = 1'b0;
    wr_addr = 7'h0;
    wr_data = 32'h0;
    rd_en = 1'b0;
    rd_addr = 7'h0;
  end
  // One write; lines scrambled once the strobe drops
  task wr(input [6:0] a, input [31:0] dat);
    begin
      @(negedge sys_clk);
      wr_en = 1'b1;
      wr_addr = a;
      wr_data = dat;
      @(negedge sys_clk);
      wr_en = 1'b0;
      wr_addr = ~a;
      wr_data = ~dat;
    end
  endtask
  // One read; answer taken a cycle after the strobe
  task rd(input [6:0] a, output [31:0] dat, output ok);
    begin
      @(negedge sys_clk);
      rd_en = 1'b1;
      rd_addr = a;
      @(negedge sys_clk);
      rd_en = 1'b0;
      rd_addr = ~a;
      dat = rd_data;
      ok = rd_valid;
    end
  endtask
  // Bridge word, analog code kept at 24 or below
  task cfg(input [4:0] an, input [3:0] dg, input [1:0] ot, gs, fs);
    wr(7'h0A, {10'h0, fs, gs, ot, 4'h0, dg, 3'h0,
      (an > 5'h18) ? 5'h18 : an});
  endtask
  // Keyed word for byte 0; factory trim bits never touched
  task prog(input [2:0] b);
    if (b > 3'h4)
      wr(7'h06, {16'h0, 8'hBD, 4'h0, 1'b0, b});
  endtask
endmodule

// File: verification/gate_driver_config_checker.sv
// Port assertions for the configuration bank
`timescale 1ns/1ps
module gate_driver_config_checker #(
  parameter PROG_CYCLES = 20
) (
  input wire sys_clk,
  input wire rst,
  input wire wr_en,
  input wire [6:0] wr_addr,
  input wire [31:0] wr_data,
  input wire rd_en,
  input wire [6:0] rd_addr,
  input wire [31:0] rd_data,
  input wire rd_valid,
  input wire [7:0] offset_phase_a,
  input wire [7:0] offset_phase_b,
  input wire high_gate_on,
  input wire low_gate_on,
  input wire [4:0] analog_deadtime,
  input wire [3:0] digital_deadtime_cycles,
  input wire otp_busy
);
  default clocking @(posedge sys_clk); endclocking
  default disable iff (rst);
  reg [31:0] busy_len;
  reg [31:0] last_wd;
  // Busy length and the last write word
  always @(posedge sys_clk) begin
    busy_len <= (rst || !otp_busy) ? 32'h0 : busy_len + 32'h1;
    last_wd <= wr_data;
  end
  sequence s_prog_req;
    wr_en && wr_addr == 7'h06 && !otp_busy;
  endsequence
  a_prog_start: assert property (s_prog_req
    ##0 wr_data[15:8] == 8'hBD ##0 wr_data[5:4] == 2'h0 |=> otp_busy)
    else $error("program not started");
  a_prog_length: assert property ($fell(otp_busy) |->
    busy_len == PROG_CYCLES) else $error("program time wrong");
  a_read_pulse: assert property (rd_valid == $past(rd_en))
    else $error("read answer late");
  a_idle_zero: assert property (!rd_valid |-> rd_data == 32'h0)
    else $error("idle read data");
  a_offset_word: assert property (rd_en && rd_addr == 7'h0C |=>
    rd_data == {16'h0, $past(offset_phase_a), $past(offset_phase_b)})
    else $error("offset word wrong");
  a_cfg_fields: assert property (wr_en && wr_addr == 7'h0A |=>
    analog_deadtime == last_wd[4:0]
    && digital_deadtime_cycles == last_wd[11:8])
    else $error("dead time fields");
  a_gates_apart: assert property (!(high_gate_on && low_gate_on))
    else $error("both gates on");
  a_dead_gap: assert property ($fell(low_gate_on)
    || $fell(high_gate_on) |-> (!high_gate_on && !low_gate_on) [*5])
    else $error("dead gap short");
endmodule
bind gate_driver_config gate_driver_config_checker #(
  .PROG_CYCLES(PROG_CYCLES)
) chk (.*);

// File: verification/gate_driver_config_test.sv
// Self-checking bench for the configuration bank
`timescale 1ns/1ps
module gate_driver_config_test;
  reg sys_clk = 1'b0;
  reg rst = 1'b1;
  reg [7:0] otp_factory_bits = 8'hA5;
  reg [3:0] temp_above = 4'h0;
  reg bridge_cmd = 1'b0;
  reg [7:0] current_demand = 8'hC8;
  wire [7:0] offset_phase_a = 8'h9C;
  wire [7:0] offset_phase_b = 8'h3F;
  wire wr_en, rd_en, rd_valid, high_gate_on, low_gate_on, otp_busy;
  wire bridge_disabled, overtemp_prewarning;
  wire [6:0] wr_addr, rd_addr;
  wire [31:0] wr_data, rd_data;
  wire [1:0] gate_current_sel, sense_filter_sel, blank_time;
  wire [4:0] analog_deadtime, oscillator_trim;
  wire [3:0] digital_deadtime_cycles, ground_short_sensitivity;
  wire [3:0] supply_short_sensitivity;
  wire [7:0] scaled_current;
  integer n_mismatch = 0;
  integer checks_done = 0;
  integer cyc = 0;
  integer i, n;
  reg [31:0] d;
  reg v;
  reg [31:0] sc [0:4] = '{32'h0, 32'h20, 32'h80, 32'hFF, 32'h100};
  always #12.5 sys_clk = ~sys_clk;
  config_host host (.sys_clk(sys_clk), .wr_en(wr_en), .wr_addr(wr_addr),
    .wr_data(wr_data), .rd_en(rd_en), .rd_addr(rd_addr),
    .rd_data(rd_data), .rd_valid(rd_valid));
  gate_driver_config #(.PROG_CYCLES(20)) dut (.*);
  // Compare and count
  task chk(input [32:0] got, input [32:0] exp);
    begin
      checks_done = checks_done + 1;
      if (got !== exp) begin
        n_mismatch = n_mismatch + 1;
        $display("[ERR] %0t got %h want %h", $time, got, exp);
      end
    end
  endtask
  // Counts, verdict, end of run
  task final_report;
    begin
      $display("checks %0d mismatches %0d", checks_done, n_mismatch);
      if (n_mismatch == 0 && checks_done > 0)
        $display("DONE - PASS");
      else
        $display("DONE - FAIL");
      $finish;
    end
  endtask
  // Ten cycles of reset with a given fuse byte
  task do_reset(input [7:0] f);
    begin
      @(negedge sys_clk);
      rst = 1'b1;
      otp_factory_bits = f;
      repeat (10) @(negedge sys_clk);
      rst = 1'b0;
    end
  endtask
  // Defaults after reset
  task defaults(input [7:0] f);
    begin
      chk(analog_deadtime, 0);
      chk({gate_current_sel, sense_filter_sel}, 0);
      chk(digital_deadtime_cycles, f[6] ? 4'h2 : 4'h4);
      chk(blank_time, f[7] ? 2'h1 : 2'h2);
      chk({ground_short_sensitivity, supply_short_sensitivity},
        f[5] ? 8'hCC : 8'h66);
      chk(oscillator_trim, f[4:0]);
      host.rd(7'h07, d, v);
      chk({v, d}, {9'h100, 16'h0, f});
    end
  endtask
  // Flip the side wanted and count cycles with both gates off
  task gap(input [32:0] want);
    begin
      n = 0;
      @(negedge sys_clk);
      bridge_cmd = ~bridge_cmd;
      @(negedge sys_clk);
      while (!high_gate_on && !low_gate_on && n < 60) begin
        n = n + 1;
        @(negedge sys_clk);
      end
      chk(n, want);
    end
  endtask
  // Set temperature, settle, check shutdown level
  task heat(input [3:0] t, input b);
    begin
      temp_above = t;
      repeat (8) @(negedge sys_clk);
      chk(bridge_disabled, b);
    end
  endtask
  // Main sequence
  initial begin
    do_reset(8'hA5);
    defaults(8'hA5);
    repeat (4) @(negedge sys_clk);
    gap(15);
    host.cfg(5'h0, 4'h0, 2'h0, 2'h0, 2'h0);
    gap(5);
    host.cfg(5'h18, 4'h0, 2'h0, 2'h0, 2'h0);
    gap(16);
    host.cfg(5'h10, 4'h4, 2'h0, 2'h0, 2'h0);
    gap(15);
    host.cfg(5'h0, 4'hF, 2'h0, 2'h0, 2'h0);
    gap(51);
    host.cfg(5'h3, 4'h7, 2'h0, 2'h2, 2'h3);
    // Effective gate drive follows the register one cycle later
    @(negedge sys_clk);
    chk({gate_current_sel, sense_filter_sel, analog_deadtime,
      digital_deadtime_cycles}, {4'hB, 5'h3, 4'h7});
    for (i = 0; i < 4; i = i + 1) begin
      host.cfg(5'h0, 4'h0, 2'h0, i[1:0], 2'h0);
      @(negedge sys_clk);
      chk(gate_current_sel, (i == 1) ? 0 : i);
      heat(4'h1, 1'b0);
      chk({overtemp_prewarning, gate_current_sel},
        (i == 1) ? 6 : 4 + i);
      heat(4'h0, 1'b0);
    end
    for (i = 0; i < 4; i = i + 1) begin
      host.cfg(5'h0, 4'h0, i[1:0], 2'h0, 2'h0);
      heat((4'hF >> i) >> 1, 1'b0);
      heat(4'hF >> i, 1'b1);
      heat(4'h1, 1'b1);
      heat(4'h0, 1'b0);
    end
    for (i = 0; i < 5; i = i + 1) begin
      host.wr(7'h0B, sc[i]);
      repeat (2) @(negedge sys_clk);
      chk(scaled_current,
        (200 * (sc[i][7:0] == 0 ? 256 : sc[i][7:0])) / 256);
    end
    host.rd(7'h0C, d, v);
    chk({v, d}, {17'h10000, 16'h9C3F});
    host.rd(7'h0B, d, v);
    chk({v, d}, 33'h100000000);
    host.wr(7'h06, 32'hAA06);
    chk(otp_busy, 0);
    host.prog(3'h6);
    chk(otp_busy, 1);
    for (n = 0; otp_busy && n < 100; n = n + 1)
      @(negedge sys_clk);
    host.rd(7'h07, d, v);
    chk(d, 32'hA5);
    host.rd(7'h06, d, v);
    host.rd(7'h07, d, v);
    chk(d, 32'hE5);
    do_reset(8'h5A);
    defaults(8'h5A);
    repeat (4) @(negedge sys_clk);
    gap(8);
    final_report;
  end
  // Hang guard
  always @(posedge sys_clk) begin
    cyc = cyc + 1;
    if (cyc == 5000) begin
      n_mismatch = n_mismatch + 1;
      final_report;
    end
  end
endmodule
